// file: common/tsaa_consts.svh
// constants of the timestamp aux/adjust block: offsets, resets, timing
`ifndef TSAA_CONSTS_SVH
`define TSAA_CONSTS_SVH
// ==================== register addresses ====================
`define TSAA_ADDR_COUNTER   32'h0000_0010
`define TSAA_ADDR_ADJUST    32'h0000_003B
`define TSAA_ADDR_AUX       32'h0000_0100
// ==================== reset values ====================
`define TSAA_COUNTER_RESET  64'h0000_0000_0000_0000
`define TSAA_ADJUST_RESET   64'h0000_0000_0000_0000
`define TSAA_AUX_RESET      32'h0000_0000
// ==================== feature query leaves and bits ====================
`define TSAA_LEAF_STRUCT    32'h0000_0007
`define TSAA_LEAF_RATIO     32'h0000_0015
`define TSAA_LEAF_EXT_FEAT  32'h8000_0001
`define TSAA_LEAF_EXT_POWER 32'h8000_0007
`define TSAA_SUBLEAF_ZERO   32'h0000_0000
`define TSAA_BIT_ADJUST     1
`define TSAA_BIT_COMBINED   27
`define TSAA_BIT_INVARIANT  8
// ==================== timing ====================
`define TSAA_CLK_PERIOD_PS  5000
`define TSAA_XTAL_PERIOD_PS 40000
`define TSAA_XTAL_DIV \
   ((`TSAA_XTAL_PERIOD_PS + `TSAA_CLK_PERIOD_PS - 1) / `TSAA_CLK_PERIOD_PS)
`define TSAA_RATIO_NUM      2
`define TSAA_RATIO_DEN      1
`endif

// file: common/tsaa_pkg.sv
// types shared by the timestamp aux/adjust block
package tsaa_pkg;
`include "tsaa_consts.svh"
   // privilege level of the requesting software
   typedef enum logic [1:0] {
      TSAA_RING0 = 2'b00,
      TSAA_RING1 = 2'b01,
      TSAA_RING2 = 2'b10,
      TSAA_RING3 = 2'b11
   } tsaa_priv_t;
   // decoded register target
   typedef enum logic [1:0] {
      TSAA_SEL_NONE    = 2'b00,
      TSAA_SEL_COUNTER = 2'b01,
      TSAA_SEL_ADJUST  = 2'b10,
      TSAA_SEL_AUX     = 2'b11
   } tsaa_sel_t;
   // state of the base timer and scaler
   typedef struct packed {
      logic [15:0] divCnt;
      logic [63:0] always_running_base_timer;
      logic [33:0] frac;
      logic [63:0] base;
   } tsaa_timer_st_t;
   // state of the feature query responder
   typedef struct packed {
      logic        ack;
      logic [31:0] eax;
      logic [31:0] ebx;
      logic [31:0] ecx;
      logic [31:0] edx;
   } tsaa_query_st_t;
   // state of the top block
   typedef struct packed {
      logic [63:0] kOff;
      logic [63:0] adj;
      logic [31:0] aux;
      logic        regAck;
      logic        regFault;
      logic [63:0] regRdData;
      logic        stAck;
      logic        stFault;
      logic [31:0] stLo;
      logic [31:0] stHi;
      logic [31:0] stSig;
   } tsaa_top_st_t;
endpackage

// file: common/tsaa_time_if.sv
// carrier between the base timer and the register logic
`timescale 1ns/1ps
interface tsaa_time_if;
   logic [63:0] artValue;   // always-running base timer count
   logic [63:0] baseCount;  // scaled count, timestamp without offset
   logic        artClear;   // clears base timer, scaler and offset
   modport src (output artValue, output baseCount, input artClear);
   modport snk (input artValue, input baseCount, output artClear);
endinterface

// file: verification/tsaa_top_bench.sv
// self-checking bench of the timestamp counter block
`timescale 1ns/1ps
`include "tsaa_consts.svh"
module tsaa_top_bench;
   import tsaa_pkg::*;
   // ==================================================
   // small divider keeps the run short; one count per clock
   localparam int unsigned XD  = 2;
   localparam int unsigned NUM = 2;
   localparam int unsigned DEN = 1;
   localparam logic [63:0] RATE42 = 64'(42 * NUM / (DEN * XD));
   localparam logic [31:0] ACNT = `TSAA_ADDR_COUNTER;
   localparam logic [31:0] AADJ = `TSAA_ADDR_ADJUST;
   localparam logic [31:0] AAUX = `TSAA_ADDR_AUX;
   logic        clk, rst, artRstReq, userReadDisable;
   tsaa_priv_t  privLevel;
   logic        regReq, regWrite, regAck, regFault;
   logic [31:0] regAddr;
   logic [63:0] regWrData, regRdData;
   logic        stampReq, stampCombined, stampAck, stampFault;
   logic [31:0] stampLo, stampHi, stampSig;
   logic        qReq, qAck;
   logic [31:0] qLeaf, qSub, qEax, qEbx, qEcx, qEdx;
   int          mismatches = 0;      // failed comparisons
   int          nChecks = 0;         // comparisons made
   logic [63:0] a0, a1, c0, c1, q;   // scratch values of the tests
   logic [31:0] s;
   logic        f;
   tsaa_top #(.XTAL_DIV(XD), .RATIO_NUM(NUM), .RATIO_DEN(DEN),
      .INVARIANT(1'b1)) i_dut (.clk(clk), .rst(rst),
      .artRstReq(artRstReq), .userReadDisable(userReadDisable),
      .privLevel(privLevel), .regReq(regReq), .regWrite(regWrite),
      .regAddr(regAddr), .regWrData(regWrData), .regAck(regAck),
      .regFault(regFault), .regRdData(regRdData), .stampReq(stampReq),
      .stampCombined(stampCombined), .stampAck(stampAck),
      .stampFault(stampFault), .stampLo(stampLo), .stampHi(stampHi),
      .stampSig(stampSig), .qReq(qReq), .qLeaf(qLeaf), .qSub(qSub),
      .qAck(qAck), .qEax(qEax), .qEbx(qEbx), .qEcx(qEcx), .qEdx(qEdx));
   // ==================================================
   // shared comparison and bus tasks
   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      nChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // the stamp moves while we look, so some checks take a window
   task automatic rng(string what, logic [63:0] v, logic [63:0] lo,
                      logic [63:0] hi);
      check(what, {63'h0, v >= lo && v <= hi}, 64'h0000_0000_0000_0001);
   endtask
   // answer stands 1 ns after the taking edge
   task automatic rw(logic w, logic [31:0] a, logic [63:0] d,
                     output logic [63:0] rd, output logic flt);
      @(posedge clk);
      regReq <= 1'b1;
      regWrite <= w;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regReq <= 1'b0;
      #1;
      rd = regRdData;
      flt = regFault;
   endtask
   task automatic st(logic comb, output logic [63:0] t,
                     output logic [31:0] sig, output logic flt);
      @(posedge clk);
      stampReq <= 1'b1;
      stampCombined <= comb;
      @(posedge clk);
      stampReq <= 1'b0;
      #1;
      t = {stampHi, stampLo};
      sig = stampSig;
      flt = stampFault;
   endtask
   task automatic qr(logic [31:0] leaf);
      @(posedge clk);
      qReq <= 1'b1;
      qLeaf <= leaf;
      qSub <= `TSAA_SUBLEAF_ZERO;
      @(posedge clk);
      qReq <= 1'b0;
      #1;
   endtask
   task automatic testDone();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==================================================
   // scenarios
   task automatic tReset();
      rw(0, AADJ, 0, q, f);
      check("adjust reset", q, `TSAA_ADJUST_RESET);
      rw(0, AAUX, 0, q, f);
      check("aux reset", q, 64'h0000_0000_0000_0000);
      rw(0, ACNT, 0, q, f);
      rng("counter after reset", q, 0, 64);
      $display("reset test done");
   endtask
   task automatic tSig();
      rw(1, AAUX, 64'hFFFF_FFFF_A5C3_1234, q, f);
      rw(0, AAUX, 0, q, f);
      check("aux readback", q, 64'h0000_0000_A5C3_1234);
      rw(0, ACNT, 0, c0, f);
      st(1, c1, s, f);
      check("combined sig", {32'h0, s}, 64'h0000_0000_A5C3_1234);
      rng("combined stamp", c1 - c0, 0, 16);
      st(0, c1, s, f);
      check("plain sig", {32'h0, s}, 64'h0000_0000_0000_0000);
      $display("signature test done");
   endtask
   task automatic tAdj();
      rw(0, AADJ, 0, a0, f);
      rw(0, ACNT, 0, c0, f);
      rw(1, AADJ, a0 + 64'h0000_0001_0000_0000, q, f);
      rw(0, AADJ, 0, a1, f);
      check("adjust write", a1, a0 + 64'h0000_0001_0000_0000);
      rw(0, ACNT, 0, c1, f);
      rng("counter follows", c1 - c0 - 64'h0000_0001_0000_0000, 0, 32);
      repeat (20) @(posedge clk);
      rw(0, AADJ, 0, q, f);
      check("adjust holds", q, a1);
      $display("adjust test done");
   endtask
   task automatic tCnt();
      rw(0, AADJ, 0, a0, f);
      rw(0, ACNT, 0, c0, f);
      rw(1, ACNT, 64'h1234_5678_0000_0000, q, f);
      rw(0, AADJ, 0, a1, f);
      rw(0, ACNT, 0, c1, f);
      rng("counter write", c1 - 64'h1234_5678_0000_0000, 0, 16);
      rng("adjust follows", 64'h1234_5678_0000_0000 - c0 - (a1 - a0), 0, 16);
      // counter just below the top must roll over past zero
      rw(1, ACNT, 64'hFFFF_FFFF_FFFF_FFF0, q, f);
      repeat (20) @(posedge clk);
      rw(0, ACNT, 0, c1, f);
      rng("counter wraps", c1, 0, 64);
      $display("counter test done");
   endtask
   task automatic tPriv();
      rw(0, AADJ, 0, a0, f);
      @(posedge clk) privLevel <= TSAA_RING1;
      rw(1, AADJ, 64'h0000_0000_0000_0005, q, f);
      check("unprivileged write", {63'h0, f}, 64'h0000_0000_0000_0001);
      @(posedge clk) privLevel <= TSAA_RING0;
      rw(0, AADJ, 0, q, f);
      check("adjust untouched", q, a0);
      rw(0, 32'h0000_0044, 0, q, f);
      check("unmapped fault", {63'h0, f}, 64'h0000_0000_0000_0001);
      $display("privilege test done");
   endtask
   task automatic tRefuse();
      for (int p = 0; p < 4; p++) begin
         for (int u = 0; u < 2; u++) begin
            @(posedge clk);
            privLevel <= tsaa_priv_t'(p);
            userReadDisable <= u[0];
            st(p[0], c1, s, f);
            check("stamp refusal", {63'h0, f}, {63'h0, u == 1 && p != 0});
            check("refused data", f ? c1 : 64'h0, 64'h0000_0000_0000_0000);
         end
      end
      @(posedge clk) privLevel <= TSAA_RING0;
      userReadDisable <= 1'b0;
      $display("refusal test done");
   endtask
   task automatic tQuery();
      qr(`TSAA_LEAF_STRUCT);
      check("adjust flag", {63'h0, qEbx[1]}, 64'h0000_0000_0000_0001);
      qr(`TSAA_LEAF_EXT_FEAT);
      check("combined flag", {63'h0, qEdx[27]}, 64'h0000_0000_0000_0001);
      qr(`TSAA_LEAF_RATIO);
      check("ratio", {qEbx, qEax}, {NUM, DEN});
      check("ecx", {32'h0, qEcx}, 64'h0);
      qr(`TSAA_LEAF_EXT_POWER);
      check("invariant flag", {63'h0, qEdx[8]}, 64'h0000_0000_0000_0001);
      $display("query test done");
   endtask
   task automatic tBase();
      rw(0, AADJ, 0, a0, f);
      st(0, c0, s, f);
      repeat (40) @(posedge clk);
      st(0, c1, s, f);
      rng("stamp rate", c1 - c0, RATE42 - 4, RATE42 + 4);
      @(posedge clk) artRstReq <= 1'b1;
      @(posedge clk) artRstReq <= 1'b0;
      st(0, c1, s, f);
      rng("stamp after base reset", c1, 0, 16);
      rw(0, AADJ, 0, q, f);
      check("adjust over base reset", q, a0);
      $display("base timer test done");
   endtask
   // ==================================================
   // clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // whole run is under two hundred cycles; this is far beyond it
   initial begin
      #50000;
      mismatches++;
      testDone();
   end
   initial begin
      {rst, artRstReq, userReadDisable, regReq, regWrite} = 5'b10000;
      {stampReq, stampCombined, qReq} = 3'b000;
      privLevel = TSAA_RING0;
      regAddr = 32'h0000_0000;
      regWrData = 64'h0000_0000_0000_0000;
      qLeaf = 32'h0000_0000;
      qSub = 32'h0000_0000;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      tReset();
      tSig();
      tAdj();
      tCnt();
      tPriv();
      tRefuse();
      tQuery();
      tBase();
      testDone();
   end
endmodule

// file: verification/tsaa_top_props.sv
// port checker of the timestamp block, bound into the top module
`timescale 1ns/1ps
`include "tsaa_consts.svh"
module tsaa_top_props #(
   parameter int unsigned RATIO_NUM = `TSAA_RATIO_NUM,
   parameter int unsigned RATIO_DEN = `TSAA_RATIO_DEN
) (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic                 artRstReq,
   input wire logic                 userReadDisable,
   input wire tsaa_pkg::tsaa_priv_t privLevel,
   input wire logic                 regReq,
   input wire logic                 regAck,
   input wire logic                 regFault,
   input wire logic [63:0]          regRdData,
   input wire logic                 stampReq,
   input wire logic                 stampCombined,
   input wire logic                 stampAck,
   input wire logic                 stampFault,
   input wire logic [31:0]          stampLo,
   input wire logic [31:0]          stampHi,
   input wire logic [31:0]          stampSig,
   input wire logic                 qReq,
   input wire logic [31:0]          qLeaf,
   input wire logic [31:0]          qSub,
   input wire logic                 qAck,
   input wire logic [31:0]          qEax,
   input wire logic [31:0]          qEbx,
   input wire logic [31:0]          qEdx
);
   import tsaa_pkg::*;
   // ==================================================
   // one clock domain, so one default clock and disable
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==================================================
   // register port
   a_reg_answer: assert property (regReq |=> regAck)
      else $error("register request left unanswered");
   a_unpriv_fault: assert property (regReq && privLevel != TSAA_RING0
      |=> regFault && regRdData == 64'h0000_0000_0000_0000)
      else $error("unprivileged register access not refused");
   // ==================================================
   // stamp port
   a_stamp_refuse: assert property (stampReq && userReadDisable
      && privLevel != TSAA_RING0 |=> stampAck && stampFault
      && stampSig == 32'h0000_0000)
      else $error("disabled stamp read not refused");
   a_stamp_allow: assert property (stampReq && !(userReadDisable
      && privLevel != TSAA_RING0) |=> stampAck && !stampFault)
      else $error("permitted stamp read refused");
   a_plain_nosig: assert property (stampReq && !stampCombined
      |=> stampSig == 32'h0000_0000)
      else $error("plain read returned a signature");
   // halves and signature only move together on a request
   a_stamp_hold: assert property (!stampReq
      |=> $stable({stampHi, stampLo, stampSig}))
      else $error("stamp result moved without a request");
   // offset cleared with the base timer, so the stamp restarts low
   a_base_clear: assert property (artRstReq ##2 stampReq
      |=> stampFault || {stampHi, stampLo} < 64'h0000_0000_0000_0010)
      else $error("stamp not restarted by base timer reset");
   // ==================================================
   // feature query port
   a_ext_leaf: assert property (qReq && qLeaf == `TSAA_LEAF_EXT_FEAT
      |=> qAck && qEdx[27])
      else $error("combined read support not flagged");
   a_struct_leaf: assert property (qReq && qLeaf == `TSAA_LEAF_STRUCT
      && qSub == 32'h0000_0000 |=> qAck && qEbx[1])
      else $error("adjust register support not flagged");
   a_ratio_leaf: assert property (qReq && qLeaf == `TSAA_LEAF_RATIO
      |=> qEbx == RATIO_NUM && qEax == RATIO_DEN)
      else $error("ratio leaf answer wrong");
   // ==================================================
   // main scenarios
   c_combined: cover property (stampReq && stampCombined ##1 !stampFault);
   c_refused: cover property (regReq ##1 regFault);
   c_base_clear: cover property (artRstReq ##3 stampAck);
endmodule

bind tsaa_top tsaa_top_props #(.RATIO_NUM(RATIO_NUM), .RATIO_DEN(RATIO_DEN))
   i_props (.clk(clk), .rst(rst), .artRstReq(artRstReq),
   .userReadDisable(userReadDisable), .privLevel(privLevel),
   .regReq(regReq), .regAck(regAck), .regFault(regFault),
   .regRdData(regRdData), .stampReq(stampReq), .stampAck(stampAck),
   .stampCombined(stampCombined), .stampFault(stampFault),
   .stampLo(stampLo), .stampHi(stampHi), .stampSig(stampSig),
   .qReq(qReq), .qLeaf(qLeaf), .qSub(qSub), .qAck(qAck), .qEax(qEax),
   .qEbx(qEbx), .qEdx(qEdx));

// file: verilog/tsaa_base_timer.sv
// always-running base timer with ratio scaler
`timescale 1ns/1ps
`include "tsaa_consts.svh"
module tsaa_base_timer #(
   parameter int unsigned XTAL_DIV  = `TSAA_XTAL_DIV,
   parameter int unsigned RATIO_NUM = `TSAA_RATIO_NUM,
   parameter int unsigned RATIO_DEN = `TSAA_RATIO_DEN,
   parameter bit          INVARIANT = 1'b1
) (
   input wire logic   clk,
   input wire logic   rst,
   tsaa_time_if.src   tm
);
   import tsaa_pkg::*;
   localparam logic [15:0] DIV_LAST = 16'(XTAL_DIV - 1);
   localparam logic [33:0] NUM34    = 34'(RATIO_NUM);
   localparam logic [33:0] DEN34    = 34'(RATIO_DEN);
   localparam bit          SCALED   = INVARIANT && (RATIO_NUM != 0);
   tsaa_timer_st_t s_q, s_d;
   logic tick, drain;
   // ==================== next state ====================
   always_comb begin
      s_d   = s_q;
      tick  = (s_q.divCnt == DIV_LAST);   // crystal rate enable
      drain = SCALED && (s_q.frac >= DEN34);
      s_d.divCnt = tick ? 16'h0000 : s_q.divCnt + 16'h0001;
      if (tick) begin
         s_d.always_running_base_timer = s_q.always_running_base_timer + 64'h0000_0000_0000_0001;
      end
      // remainder carries fraction so base*den + frac = art*num
      s_d.frac = s_q.frac + (tick && SCALED ? NUM34 : 34'h0_0000_0000)
                 - (drain ? DEN34 : 34'h0_0000_0000);
      // no stall input exists: rate never follows power state
      if (SCALED) begin
         s_d.base = s_q.base + {63'h0, drain};
      end else begin
         s_d.base = s_q.base + 64'h0000_0000_0000_0001;
      end
      if (tm.artClear) begin
         s_d = '0;
      end
   end
   // ==================== registers ====================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tm.artValue  = s_q.always_running_base_timer;
   assign tm.baseCount = s_q.base;
endmodule

// file: verilog/tsaa_feature_query.sv
// feature query responder for the timestamp facility
`timescale 1ns/1ps
`include "tsaa_consts.svh"
module tsaa_feature_query #(
   parameter int unsigned RATIO_NUM = `TSAA_RATIO_NUM,
   parameter int unsigned RATIO_DEN = `TSAA_RATIO_DEN,
   parameter bit          INVARIANT = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        qReq,
   input  wire logic [31:0] qLeaf,
   input  wire logic [31:0] qSub,
   output logic             qAck,
   output logic [31:0]      qEax,
   output logic [31:0]      qEbx,
   output logic [31:0]      qEcx,
   output logic [31:0]      qEdx
);
   import tsaa_pkg::*;
   tsaa_query_st_t s_q, s_d;
   // ==================== answer decode ====================
   always_comb begin
      s_d     = '0;       // unknown leaves answer all zero
      s_d.ack = qReq;
      if (qReq) begin
         case (qLeaf)
            `TSAA_LEAF_STRUCT: begin
               if (qSub == `TSAA_SUBLEAF_ZERO) begin
                  s_d.ebx[`TSAA_BIT_ADJUST] = 1'b1;
               end
            end
            `TSAA_LEAF_RATIO: begin
               s_d.eax = 32'(RATIO_DEN);
               s_d.ebx = 32'(RATIO_NUM);
            end
            `TSAA_LEAF_EXT_FEAT: begin
               s_d.edx[`TSAA_BIT_COMBINED] = 1'b1;
            end
            `TSAA_LEAF_EXT_POWER: begin
               s_d.edx[`TSAA_BIT_INVARIANT] = INVARIANT;
            end
            default: begin
               s_d.eax = 32'h0000_0000;
            end
         endcase
      end
   end
   // ==================== registers ====================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign qAck = s_q.ack;
   assign qEax = s_q.eax;
   assign qEbx = s_q.ebx;
   assign qEcx = s_q.ecx;
   assign qEdx = s_q.edx;
endmodule

// file: verilog/tsaa_top.sv
// timestamp counter, adjustment, signature and combined read
`timescale 1ns/1ps
`include "tsaa_consts.svh"

// Function
// - 32-bit signature register, privileged write only
// - combined read returns stamp halves plus signature
// - stamp and signature captured in one cycle
// - read-disable bit refuses unprivileged stamp reads
// - combined read support flagged in extended leaf
// - counter write touches this processor only
// - 64-bit adjustment register per logical processor
// - adjustment register clears on processor reset
// - counter write delta also added to adjustment
// - adjustment write delta also added to counter
// - adjustment changes only on those two writes
// - adjustment support flagged in structured leaf
// - stamp derived from crystal-rate base timer
// - stamp equals base times ratio plus offset
// - offset changed only by privileged writes and base timer reset
// - base timer reset clears stamp and offset
// - 64-bit counter, zero after processor reset
// - stamp advances at constant rate always
module tsaa_top #(
   parameter int unsigned XTAL_DIV  = `TSAA_XTAL_DIV,
   parameter int unsigned RATIO_NUM = `TSAA_RATIO_NUM,
   parameter int unsigned RATIO_DEN = `TSAA_RATIO_DEN,
   parameter bit          INVARIANT = 1'b1
) (
   input  wire logic               clk,
   input  wire logic               rst,
   // base timer reset request, same clock domain
   input  wire logic               artRstReq,
   // read-disable control and current privilege
   input  wire logic               userReadDisable,
   input  wire tsaa_pkg::tsaa_priv_t privLevel,
   // model register read and write port
   input  wire logic               regReq,
   input  wire logic               regWrite,
   input  wire logic [31:0]        regAddr,
   input  wire logic [63:0]        regWrData,
   output logic                    regAck,
   output logic                    regFault,
   output logic [63:0]             regRdData,
   // plain and combined stamp read port
   input  wire logic               stampReq,
   input  wire logic               stampCombined,
   output logic                    stampAck,
   output logic                    stampFault,
   output logic [31:0]             stampLo,
   output logic [31:0]             stampHi,
   output logic [31:0]             stampSig,
   // feature query port
   input  wire logic               qReq,
   input  wire logic [31:0]        qLeaf,
   input  wire logic [31:0]        qSub,
   output logic                    qAck,
   output logic [31:0]             qEax,
   output logic [31:0]             qEbx,
   output logic [31:0]             qEcx,
   output logic [31:0]             qEdx
);
   import tsaa_pkg::*;

   // ==================== elaboration checks ====================
   // scaler drains one denominator per clock, so the ratio
   // must not outrun the clock between two crystal ticks
   if (XTAL_DIV < 1 || XTAL_DIV > 65536) begin : gBadDiv
      $error("crystal divider out of range");
   end
   if (RATIO_NUM != 0 && RATIO_DEN == 0) begin : gBadDen
      $error("ratio denominator must be nonzero");
   end
   if (RATIO_NUM != 0 &&
       64'(RATIO_NUM) > 64'(RATIO_DEN) * 64'(XTAL_DIV)) begin : gBadRatio
      $error("ratio too high for the clock rate");
   end

   // ==================== state ====================
   tsaa_top_st_t s_q;          // all registered state
   tsaa_top_st_t s_d;          // next value of the state
   tsaa_time_if  tm ();        // base timer carrier

   // ==================== combinational helpers ====================
   logic [63:0] tscNow;        // current timestamp value
   logic [63:0] delta;         // signed change of a write
   logic        isPriv;        // requester at most privileged level
   logic        regTaken;      // register request accepted
   tsaa_sel_t   sel;           // decoded register target

   // base timer and ratio scaler, shared rate for the whole block
   tsaa_base_timer #(
      .XTAL_DIV  (XTAL_DIV),
      .RATIO_NUM (RATIO_NUM),
      .RATIO_DEN (RATIO_DEN),
      .INVARIANT (INVARIANT)
   ) uTimer (
      .clk (clk),
      .rst (rst),
      .tm  (tm.src)
   );

   // feature query answers, registered inside the responder
   tsaa_feature_query #(
      .RATIO_NUM (RATIO_NUM),
      .RATIO_DEN (RATIO_DEN),
      .INVARIANT (INVARIANT)
   ) uQuery (
      .clk   (clk),
      .rst   (rst),
      .qReq  (qReq),
      .qLeaf (qLeaf),
      .qSub  (qSub),
      .qAck  (qAck),
      .qEax  (qEax),
      .qEbx  (qEbx),
      .qEcx  (qEcx),
      .qEdx  (qEdx)
   );

   // base timer reset reaches timer, scaler and offset together
   assign tm.artClear = artRstReq;

   // timestamp is the scaled base plus the offset term
   assign tscNow = tm.baseCount + s_q.kOff;

   // ==================== address decode ====================
   always_comb begin
      case (regAddr)
         `TSAA_ADDR_COUNTER: begin
            sel = TSAA_SEL_COUNTER;
         end
         `TSAA_ADDR_ADJUST: begin
            sel = TSAA_SEL_ADJUST;
         end
         `TSAA_ADDR_AUX: begin
            sel = TSAA_SEL_AUX;
         end
         default: begin
            sel = TSAA_SEL_NONE;   // unmapped: answered with a fault
         end
      endcase
   end

   // model registers are reachable from the top level only
   assign isPriv   = (privLevel == TSAA_RING0);
   assign regTaken = regReq && isPriv && (sel != TSAA_SEL_NONE);

   // ==================== next state ====================
   always_comb begin
      s_d   = s_q;
      delta = 64'h0000_0000_0000_0000;

      // answer strobes last one cycle
      s_d.regAck   = 1'b0;
      s_d.regFault = 1'b0;
      s_d.stAck    = 1'b0;
      s_d.stFault  = 1'b0;

      // ---------- stamp read port ----------
      if (stampReq) begin
         s_d.stAck = 1'b1;
         if (userReadDisable && !isPriv) begin
            // refused alike for plain and combined form
            s_d.stFault = 1'b1;
            s_d.stLo    = 32'h0000_0000;
            s_d.stHi    = 32'h0000_0000;
            s_d.stSig   = 32'h0000_0000;
         end else begin
            // one edge samples both, nothing can slip between
            s_d.stLo  = tscNow[31:0];
            s_d.stHi  = tscNow[63:32];
            // plain form leaves the signature field at zero
            s_d.stSig = stampCombined ? s_q.aux
                                      : 32'h0000_0000;
         end
      end

      // ---------- model register port ----------
      if (regReq) begin
         s_d.regAck    = 1'b1;
         s_d.regFault  = !regTaken;
         s_d.regRdData = 64'h0000_0000_0000_0000;
      end

      if (regTaken && !regWrite) begin
         // read side: show the live values
         case (sel)
            TSAA_SEL_COUNTER: begin
               s_d.regRdData = tscNow;
            end
            TSAA_SEL_ADJUST: begin
               s_d.regRdData = s_q.adj;
            end
            TSAA_SEL_AUX: begin
               s_d.regRdData = {32'h0000_0000, s_q.aux};
            end
            default: begin
               s_d.regRdData = 64'h0000_0000_0000_0000;
            end
         endcase
      end

      if (regTaken && regWrite) begin
         // write side: only this instance's state is touched
         case (sel)
            TSAA_SEL_COUNTER: begin
               // signed change of the counter moves both offset
               // and adjustment; all sums wrap at 64 bits
               delta     = regWrData - tscNow;
               s_d.kOff  = s_q.kOff + delta;
               s_d.adj   = s_q.adj + delta;
            end
            TSAA_SEL_ADJUST: begin
               // same delta reaches the counter through offset
               delta     = regWrData - s_q.adj;
               s_d.adj   = regWrData;
               s_d.kOff  = s_q.kOff + delta;
            end
            TSAA_SEL_AUX: begin
               s_d.aux = regWrData[31:0];
            end
            default: begin
               s_d.aux = s_q.aux;
            end
         endcase
      end

      // base timer reset wins over a same-cycle offset write;
      // the adjustment register is not cleared and still takes the write
      if (artRstReq) begin
         s_d.kOff = 64'h0000_0000_0000_0000;
      end
   end

   // ==================== registers ====================
   // adjustment is not touched by time passing: only the
   // write branches above assign it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q           <= '0;
         s_q.kOff      <= `TSAA_COUNTER_RESET;
         s_q.adj       <= `TSAA_ADJUST_RESET;
         s_q.aux       <= `TSAA_AUX_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ==================== outputs ====================
   // all driven from the state register
   assign regAck     = s_q.regAck;
   assign regFault   = s_q.regFault;
   assign regRdData  = s_q.regRdData;
   assign stampAck   = s_q.stAck;
   assign stampFault = s_q.stFault;
   assign stampLo    = s_q.stLo;
   assign stampHi    = s_q.stHi;
   assign stampSig   = s_q.stSig;
endmodule
